// *** verilog/power_monitor_pkg.sv ***
// Purpose: shared constants and types of the power monitor result register set
// Assumes: 16-bit registers addressed by a 3-bit pointer over the two-wire serial port
// Notes: math follows current = shunt*cal/4096 and power = |current|*bus/5000
//
// Notes on behaviour
// - bus voltage count sits in bits 15..3; host shifts right by three
// - one shifted bus count is 4 mV; 16 V full scale is count 0FA0
// - 32 V full scale is count 1F40, still 4 mV per count
// - range select value zero picks the 16 V bus range
// - ready flag sets only after conversion and both multiplications are done
// - writing an active operating mode into configuration clears the ready flag
// - any read of the power register clears the ready flag
// - latest results stay readable regardless of the ready flag
// - overflow flag in bit 0 marks current or power calculation out of range
// - power is current magnitude times bus voltage, scaled through calibration
// - current is shunt times calibration, two's complement with sign in bit 15
// - calibration bit 0 is unused, reads zero and cannot be written
// - host writes calibration; device derives current and power scale from it
// - power, current and calibration registers reset to zero
package power_monitor_pkg;
   localparam logic [2:0] REG_CONFIG = 3'h0;
   localparam logic [2:0] REG_SHUNT = 3'h1;
   localparam logic [2:0] REG_BUS = 3'h2;
   localparam logic [2:0] REG_POWER = 3'h3;
   localparam logic [2:0] REG_CURRENT = 3'h4;
   localparam logic [2:0] REG_CAL = 3'h5;

   localparam logic [15:0] CONFIG_RESET = 16'h0007;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [15:0] CAL_RESET = 16'h0000;
   localparam logic [15:0] CAL_USED_MASK = 16'hFFFE;

   localparam int MODE_LSB = 0;
   localparam int RANGE_BIT = 13;
   localparam logic [2:0] MODE_POWER_DOWN = 3'h0;
   localparam logic [2:0] MODE_ADC_OFF = 3'h4;

   localparam int BUS_FIELD_LSB = 3;
   localparam int READY_BIT = 1;
   localparam int OVF_BIT = 0;
   localparam int BUS_LSB_MV = 4;
   localparam logic [12:0] FULL_SCALE_16V = 13'h0FA0;
   localparam logic [12:0] FULL_SCALE_32V = 13'h1F40;

   localparam int CURRENT_SHIFT = 12;
   localparam logic [15:0] POWER_DIVISOR = 16'h1388;

   localparam int SYNC_STAGES = 3;

   typedef struct packed {
      logic [15:0] shunt;
      logic [12:0] bus_count;
   } sample_t;
endpackage

// *** verilog/power_monitor_regs.sv ***
// Purpose: result, calibration and configuration registers with a two-wire serial slave
// Assumes: front end delivers one sample per conversion cycle on ref_clk
// Notes: samples arriving while the math runs (two cycles) are dropped
`timescale 1ns/10ps
module power_monitor_regs #(
   parameter logic [6:0] SLAVE_ADDR = 7'h40
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic sample_valid,
   input wire power_monitor_pkg::sample_t sample,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   output logic [15:0] device_config
);
   typedef enum logic [6:0] {
      S_IDLE = 7'b0000001,
      S_ADDR = 7'b0000010,
      S_ADDR_ACK = 7'b0000100,
      S_RX = 7'b0001000,
      S_RX_ACK = 7'b0010000,
      S_TX = 7'b0100000,
      S_TX_ACK = 7'b1000000
   } link_state_t;

   typedef enum logic [2:0] {
      C_IDLE = 3'b001,
      C_CUR = 3'b010,
      C_PWR = 3'b100
   } calc_state_t;

   link_state_t state;
   calc_state_t calc_state;
   logic [power_monitor_pkg::SYNC_STAGES-1:0] scl_sync;
   logic [power_monitor_pkg::SYNC_STAGES-1:0] sda_sync;
   logic scl_lvl;
   logic sda_lvl;
   logic scl_q;
   logic sda_q;
   logic [3:0] bit_cnt;
   logic [7:0] shreg;
   logic read_mode;
   logic [1:0] byte_idx;
   logic [2:0] pointer;
   logic [7:0] msb_hold;
   logic [15:0] tx_word;
   logic master_ack;
   logic mode_clear;
   logic power_read;
   logic [15:0] scale_calibration;
   logic [15:0] shunt_drop_result;
   logic [12:0] bus_count_result;
   logic [15:0] power_result;
   logic [15:0] current_result;
   logic conversion_ready_flag;
   logic math_overflow_flag;
   logic commit;
   power_monitor_pkg::sample_t sample_hold;
   logic signed [32:0] cur_wide;

   wire scl_rise = scl_lvl & ~scl_q;
   wire scl_fall = ~scl_lvl & scl_q;
   wire start_seen = scl_lvl & scl_q & sda_q & ~sda_lvl;
   wire stop_seen = scl_lvl & scl_q & ~sda_q & sda_lvl;
   wire [15:0] bus_voltage_result = {bus_count_result, 1'b0,
                                     conversion_ready_flag, math_overflow_flag};

   function automatic logic [15:0] reg_read(input logic [2:0] ptr);
      unique case (ptr)
         power_monitor_pkg::REG_CONFIG: reg_read = device_config;
         power_monitor_pkg::REG_SHUNT: reg_read = shunt_drop_result;
         power_monitor_pkg::REG_BUS: reg_read = bus_voltage_result;
         power_monitor_pkg::REG_POWER: reg_read = power_result;
         power_monitor_pkg::REG_CURRENT: reg_read = current_result;
         power_monitor_pkg::REG_CAL: reg_read = scale_calibration;
         default: reg_read = 16'h0000;
      endcase
   endfunction

   // always_comb follows the registers the function reads, not only its argument;
   // a bit-select straight on a call result would not be accepted
   logic [15:0] read_word;
   always_comb begin
      read_word = reg_read(pointer);
   end

   // pins are asynchronous: three stages, a level counts once stages two and three agree
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         scl_sync <= '1;
         sda_sync <= '1;
         scl_lvl <= 1'b1;
         sda_lvl <= 1'b1;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[power_monitor_pkg::SYNC_STAGES-2:0], scl_in};
         sda_sync <= {sda_sync[power_monitor_pkg::SYNC_STAGES-2:0], sda_in};
         if (scl_sync[2] == scl_sync[1]) begin
            scl_lvl <= scl_sync[2];
         end
         if (sda_sync[2] == sda_sync[1]) begin
            sda_lvl <= sda_sync[2];
         end
         scl_q <= scl_lvl;
         sda_q <= sda_lvl;
      end
   end

   // serial slave: pointer byte, then MSB-first words; reads snapshot a whole word
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state <= S_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         read_mode <= 1'b0;
         byte_idx <= 2'h0;
         pointer <= power_monitor_pkg::REG_CONFIG;
         msb_hold <= 8'h00;
         tx_word <= 16'h0000;
         master_ack <= 1'b0;
         sda_out <= 1'b0;
         sda_oe_n <= 1'b1;
         mode_clear <= 1'b0;
         power_read <= 1'b0;
         device_config <= power_monitor_pkg::CONFIG_RESET;
         scale_calibration <= power_monitor_pkg::CAL_RESET;
      end else begin
         mode_clear <= 1'b0;
         power_read <= 1'b0;
         if (start_seen) begin
            state <= S_ADDR;
            bit_cnt <= 4'h0;
            byte_idx <= 2'h0;
            sda_oe_n <= 1'b1;
         end else if (stop_seen) begin
            state <= S_IDLE;
            sda_oe_n <= 1'b1;
         end else if (scl_rise) begin
            if (state == S_ADDR || state == S_RX) begin
               shreg <= {shreg[6:0], sda_lvl};
               bit_cnt <= bit_cnt + 4'h1;
            end else if (state == S_TX_ACK) begin
               master_ack <= ~sda_lvl;
            end
         end else if (scl_fall) begin
            unique case (state)
               S_IDLE: begin
                  sda_oe_n <= 1'b1;
               end
               S_ADDR: begin
                  if (bit_cnt == 4'h8) begin
                     if (shreg[7:1] == SLAVE_ADDR) begin
                        state <= S_ADDR_ACK;
                        read_mode <= shreg[0];
                        sda_oe_n <= 1'b0;
                     end else begin
                        state <= S_IDLE;
                     end
                  end
               end
               S_ADDR_ACK: begin
                  bit_cnt <= 4'h0;
                  if (read_mode) begin
                     tx_word <= read_word;
                     power_read <= (pointer == power_monitor_pkg::REG_POWER);
                     byte_idx <= 2'h0;
                     sda_oe_n <= read_word[15];
                     bit_cnt <= 4'h1;
                     state <= S_TX;
                  end else begin
                     sda_oe_n <= 1'b1;
                     state <= S_RX;
                  end
               end
               S_RX: begin
                  if (bit_cnt == 4'h8) begin
                     state <= S_RX_ACK;
                     sda_oe_n <= 1'b0;
                     if (byte_idx == 2'h0) begin
                        pointer <= shreg[2:0];
                        byte_idx <= 2'h1;
                     end else if (byte_idx == 2'h1) begin
                        msb_hold <= shreg;
                        byte_idx <= 2'h2;
                     end else begin
                        byte_idx <= 2'h1;
                        if (pointer == power_monitor_pkg::REG_CONFIG) begin
                           device_config <= {msb_hold, shreg};
                           // power-down and converter-off leave the flag alone
                           if (shreg[2:0] != power_monitor_pkg::MODE_POWER_DOWN &&
                               shreg[2:0] != power_monitor_pkg::MODE_ADC_OFF) begin
                              mode_clear <= 1'b1;
                           end
                        end else if (pointer == power_monitor_pkg::REG_CAL) begin
                           scale_calibration <= {msb_hold, shreg} &
                                                power_monitor_pkg::CAL_USED_MASK;
                        end
                     end
                  end
               end
               S_RX_ACK: begin
                  sda_oe_n <= 1'b1;
                  bit_cnt <= 4'h0;
                  state <= S_RX;
               end
               S_TX: begin
                  if (bit_cnt == 4'h8) begin
                     sda_oe_n <= 1'b1;
                     state <= S_TX_ACK;
                  end else begin
                     sda_oe_n <= byte_idx[0] ? tx_word[3'(7 - bit_cnt)]
                                             : tx_word[4'(15 - bit_cnt)];
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
               S_TX_ACK: begin
                  if (master_ack) begin
                     byte_idx <= {1'b0, ~byte_idx[0]};
                     sda_oe_n <= byte_idx[0] ? tx_word[15] : tx_word[7];
                     bit_cnt <= 4'h1;
                     state <= S_TX;
                  end else begin
                     state <= S_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // math path
   logic signed [32:0] cur_shift;
   logic [15:0] cur_val;
   logic [15:0] cur_mag;
   logic cur_ovf;
   logic [12:0] full_scale;
   logic [12:0] bus_clamped;
   logic [28:0] pwr_wide;

   always_comb begin
      cur_shift = cur_wide >>> power_monitor_pkg::CURRENT_SHIFT;
      cur_val = cur_shift[15:0];
      cur_ovf = !((&cur_shift[32:15]) || !(|cur_shift[32:15]));
      cur_mag = cur_val[15] ? 16'(-cur_val) : cur_val;
      full_scale = device_config[power_monitor_pkg::RANGE_BIT] ?
                   power_monitor_pkg::FULL_SCALE_32V :
                   power_monitor_pkg::FULL_SCALE_16V;
      bus_clamped = (sample_hold.bus_count > full_scale) ? full_scale : sample_hold.bus_count;
      pwr_wide = 29'(({13'h0000, cur_mag} * {16'h0000, bus_clamped}) /
                     {13'h0000, power_monitor_pkg::POWER_DIVISOR});
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         calc_state <= C_IDLE;
         sample_hold <= '0;
         cur_wide <= '0;
         commit <= 1'b0;
         shunt_drop_result <= power_monitor_pkg::RESULT_RESET;
         bus_count_result <= 13'h0000;
         power_result <= power_monitor_pkg::RESULT_RESET;
         current_result <= power_monitor_pkg::RESULT_RESET;
         math_overflow_flag <= 1'b0;
      end else begin
         commit <= 1'b0;
         unique case (calc_state)
            C_IDLE: begin
               if (sample_valid) begin
                  sample_hold <= sample;
                  calc_state <= C_CUR;
               end
            end
            C_CUR: begin
               cur_wide <= $signed(sample_hold.shunt) *
                           $signed({1'b0, scale_calibration &
                                    power_monitor_pkg::CAL_USED_MASK});
               calc_state <= C_PWR;
            end
            C_PWR: begin
               // all results land on one edge so no read sees two cycles
               shunt_drop_result <= sample_hold.shunt;
               bus_count_result <= bus_clamped;
               current_result <= cur_val;
               power_result <= pwr_wide[15:0];
               math_overflow_flag <= cur_ovf | (|pwr_wide[28:16]);
               commit <= 1'b1;
               calc_state <= C_IDLE;
            end
         endcase
      end
   end

   // a completion in the same cycle as a clear wins
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         conversion_ready_flag <= 1'b0;
      end else if (commit) begin
         conversion_ready_flag <= 1'b1;
      end else if (mode_clear || power_read) begin
         conversion_ready_flag <= 1'b0;
      end
   end
endmodule

// *** dv/power_monitor_regs_asserts.sv ***
// Purpose: port checks of the register block
// Assumes: scl_in toggles slowly against ref_clk
// Notes: data pin timing judged from raw scl_in
`timescale 1ns/10ps
module power_monitor_regs_asserts (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic [15:0] device_config
);
   logic [8:0] low_run;
   logic [3:0] since_fall;
   always_ff @(posedge ref_clk) begin
      if (!reset_n || sda_oe_n) begin
         low_run <= 9'h000;
      end else if (low_run != 9'h1FF) begin
         low_run <= low_run + 9'h001;
      end
   end
   // saturates so a long low phase cannot wrap back into the window
   always_ff @(posedge ref_clk) begin
      if (!reset_n || scl_in) begin
         since_fall <= 4'h0;
      end else if (since_fall != 4'hF) begin
         since_fall <= since_fall + 4'h1;
      end
   end
   sda_out_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      sda_out == 1'b0) else $error("sda_out high");
   cfg_reset_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(reset_n) |-> device_config == 16'h0007) else $error("config reset");
   idle_reset_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(reset_n) |-> sda_oe_n [*4]) else $error("drive after reset");
   hi_stable_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $past(reset_n) && $changed(sda_oe_n) |-> !scl_in) else $error("move in high");
   edge_lag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $past(reset_n) && $changed(sda_oe_n) |-> since_fall inside {[4'h2:4'hC]})
      else $error("move not after fall");
   ack_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $fell(sda_oe_n) |=> !sda_oe_n [*8]) else $error("drive too short");
   drive_end_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $fell(sda_oe_n) |-> ##[1:400] sda_oe_n) else $error("drive too long");
   run_cap_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      low_run < 9'h190) else $error("low run too long");
endmodule
bind power_monitor_regs power_monitor_regs_asserts i_chk (
   .ref_clk(ref_clk),
   .reset_n(reset_n),
   .scl_in(scl_in),
   .sda_out(sda_out),
   .sda_oe_n(sda_oe_n),
   .device_config(device_config)
);

// *** dv/serial_host_model.sv ***
// Purpose: two-wire bus master model
// Assumes: bench resolves the data wire with a pull-up
// Notes: 125 ns bit time, no clock stretching
`timescale 1ns/10ps
module serial_host_model #(
   parameter logic [6:0] ADDR = 7'h40
) (
   output logic scl,
   output logic sda_drv_n,
   input wire logic sda_line
);
   localparam realtime Q = 31.25;
   initial begin
      scl = 1'b1;
      sda_drv_n = 1'b1;
   end
   // data moves only in the low phase, so a move never reads as start or stop
   task automatic bit_io(input logic b, output logic r);
      sda_drv_n = b;
      #(Q);
      scl = 1'b1;
      #(Q);
      r = sda_line;
      #(Q);
      scl = 1'b0;
      #(Q);
   endtask
   task automatic start();
      sda_drv_n = 1'b0;
      #(Q);
      scl = 1'b0;
      #(Q);
   endtask
   task automatic stop();
      sda_drv_n = 1'b0;
      #(Q);
      scl = 1'b1;
      #(Q);
      sda_drv_n = 1'b1;
      #(2 * Q);
   endtask
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, ack);
   endtask
   task automatic get_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(last, r);
   endtask
   task automatic write_reg(input logic [2:0] ptr, input logic [15:0] d, output logic ok);
      logic [3:0] a;
      start();
      put_byte({ADDR, 1'b0}, a[0]);
      put_byte({5'h00, ptr}, a[1]);
      put_byte(d[15:8], a[2]);
      put_byte(d[7:0], a[3]);
      stop();
      ok = (a == 4'h0);
   endtask
   task automatic read_reg(input logic [2:0] ptr, output logic [15:0] d, output logic ok);
      logic [2:0] a;
      start();
      put_byte({ADDR, 1'b0}, a[0]);
      put_byte({5'h00, ptr}, a[1]);
      stop();
      start();
      put_byte({ADDR, 1'b1}, a[2]);
      get_byte(1'b0, d[15:8]);
      get_byte(1'b1, d[7:0]);
      stop();
      ok = (a == 3'h0);
   endtask
endmodule

// *** dv/test_power_monitor_result_registers.sv ***
// Purpose: self-checking bench of the register block
// Assumes: samples fed directly, registers reached over the two-wire port
// Notes: expected words worked out by hand from the scaling equations
`timescale 1ns/10ps
`define CHECK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         fails++; \
         $display("wrong value at %0t: got %h exp %h", $time, got, exp); \
      end \
   end
module test_power_monitor_result_registers;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic sample_valid = 1'b0;
   power_monitor_pkg::sample_t sample = '0;
   logic scl;
   logic host_drv_n;
   logic sda_out;
   logic sda_oe_n;
   logic [15:0] device_config;
   wire sda_line;
   int fails = 0;
   int num_checks = 0;
   assign sda_line = sda_oe_n & host_drv_n;
   always #2 ref_clk = ~ref_clk;
   power_monitor_regs i_dut (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .sample_valid(sample_valid),
      .sample(sample),
      .scl_in(scl),
      .sda_in(sda_line),
      .sda_out(sda_out),
      .sda_oe_n(sda_oe_n),
      .device_config(device_config)
   );
   serial_host_model i_host (
      .scl(scl),
      .sda_drv_n(host_drv_n),
      .sda_line(sda_line)
   );
   task automatic rd(input logic [2:0] ptr, input logic [15:0] exp);
      logic [15:0] d;
      logic ok;
      // off-grid start keeps every pin edge clear of a rising clock edge
      @(negedge ref_clk);
      #(0.13);
      i_host.read_reg(ptr, d, ok);
      `CHECK(ok, 1'b1)
      `CHECK(d, exp)
   endtask
   task automatic wr(input logic [2:0] ptr, input logic [15:0] d);
      logic ok;
      @(negedge ref_clk);
      #(0.13);
      i_host.write_reg(ptr, d, ok);
      `CHECK(ok, 1'b1)
   endtask
   task automatic feed(input logic [15:0] sh, input logic [12:0] bc);
      @(negedge ref_clk);
      sample_valid = 1'b1;
      sample = '{shunt: sh, bus_count: bc};
      @(negedge ref_clk);
      sample_valid = 1'b0;
      repeat (8) @(negedge ref_clk);
   endtask
   task automatic t_reset();
      `CHECK(device_config, 16'h0007)
      rd(3'h3, 16'h0000);
      rd(3'h4, 16'h0000);
      rd(3'h5, 16'h0000);
      rd(3'h6, 16'h0000);
   endtask
   task automatic t_scale();
      wr(3'h5, 16'h5001);
      rd(3'h5, 16'h5000);
      feed(16'h07D0, 13'h0BB3);
      rd(3'h2, {13'h0BB3, 3'b010});
      rd(3'h1, 16'h07D0);
      rd(3'h4, 16'h2710);
      rd(3'h3, 16'h1766);
      rd(3'h2, {13'h0BB3, 3'b000});
      feed(16'hF830, 13'h0BB3);
      rd(3'h4, 16'hD8F0);
      rd(3'h3, 16'h1766);
   endtask
   task automatic t_ovf();
      wr(3'h5, 16'hFFFE);
      feed(16'h7FFF, 13'h0BB3);
      rd(3'h2, {13'h0BB3, 3'b011});
      wr(3'h5, 16'h0000);
      // write to a result register is acked and dropped
      wr(3'h3, 16'hFFFF);
      feed(16'h7FFF, 13'h0BB3);
      rd(3'h3, 16'h0000);
      rd(3'h2, {13'h0BB3, 3'b000});
   endtask
   task automatic t_range();
      feed(16'h0000, 13'h1FFF);
      rd(3'h2, {13'h0FA0, 3'b010});
      wr(3'h0, 16'h2000);
      `CHECK(device_config, 16'h2000)
      rd(3'h2, {13'h0FA0, 3'b010});
      wr(3'h0, 16'h2004);
      rd(3'h2, {13'h0FA0, 3'b010});
      wr(3'h0, 16'h2007);
      rd(3'h2, {13'h0FA0, 3'b000});
      feed(16'h0000, 13'h1FFF);
      rd(3'h2, {13'h1F40, 3'b010});
   endtask
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge ref_clk);
      reset_n = 1'b1;
      repeat (8) @(negedge ref_clk);
      t_reset();
      t_scale();
      t_ovf();
      t_range();
      print_verdict();
   end
endmodule
